// *** hdl/dcc_top.sv ***
// dma channel control b register bank and checksum input unit behind avalon-mm
`timescale 1ns/1ns
`default_nettype none
module dcc_top #(
  parameter int CH = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire dcc_pkg::dcc_avl_req_t avl_req,
  output logic [31:0] avl_readdata,
  output logic avl_waitrequest,
  output logic ctrl_enable,
  output logic [CH-1:0] ch_suspended,
  output dcc_pkg::dcc_cfg_t [CH-1:0] ch_cfg,
  output logic [31:0] crc_sum,
  output logic crc_valid
);
  localparam int IW = (CH > 1) ? $clog2(CH) : 1;

  // ****************************************
  // bus slave
  // ****************************************
  dcc_pkg::dcc_bus_st_t bs_r;
  dcc_pkg::dcc_bus_st_t bs_nxt;
  logic [31:0] rdata_r;
  logic wait_r;
  logic [31:0] rd_mux;

  wire req_any = avl_req.read | avl_req.write;
  wire commit = (bs_r == dcc_pkg::BS_ACK) & avl_req.write;
  wire [3:0] be = avl_req.byteenable;
  wire [31:0] wd = avl_req.writedata;
  wire hit_ctrl = avl_req.address == dcc_pkg::OFF_CTRL;
  wire hit_crc = avl_req.address == dcc_pkg::OFF_CRC_IN;
  wire hit_sum = avl_req.address == dcc_pkg::OFF_CRC_SUM;
  wire hit_stat = avl_req.address == dcc_pkg::OFF_STATUS;
  wire hit_chid = avl_req.address == dcc_pkg::OFF_CHAN_SEL;
  wire hit_cb = avl_req.address == dcc_pkg::OFF_CHAN_CTRL_B;

  always_comb begin
    bs_nxt = bs_r;
    case (bs_r)
      dcc_pkg::BS_IDLE: begin
        if (req_any) begin
          bs_nxt = dcc_pkg::BS_ACK;
        end
      end
      dcc_pkg::BS_ACK: bs_nxt = dcc_pkg::BS_IDLE;
      default: bs_nxt = dcc_pkg::BS_IDLE;
    endcase
  end

  // one wait cycle, then a single-cycle answer; read data is captured with it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bs_r <= dcc_pkg::BS_IDLE;
      wait_r <= 1'b1;
      rdata_r <= dcc_pkg::UNMAPPED_RD;
    end else begin
      bs_r <= bs_nxt;
      wait_r <= !(bs_r == dcc_pkg::BS_IDLE && req_any);
      if (bs_r == dcc_pkg::BS_IDLE && avl_req.read) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // ****************************************
  // control and channel index
  // ****************************************
  logic en_r;
  logic [1:0] beat_r;
  logic [IW-1:0] chid_r;
  wire [31:0] ctrl_rd = {28'h0, beat_r, en_r, 1'b0};
  wire [31:0] ctrl_new = dcc_pkg::dcc_be_merge(ctrl_rd, wd, be);
  wire [31:0] chid_new = dcc_pkg::dcc_be_merge({{(32-IW){1'b0}}, chid_r}, wd, be);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_r <= 1'b0;
      beat_r <= dcc_pkg::BEAT_RST;
      chid_r <= '0;
    end else begin
      if (commit && hit_ctrl) begin
        en_r <= ctrl_new[dcc_pkg::CTRL_EN_BIT];
        beat_r <= ctrl_new[dcc_pkg::CTRL_BEAT_LO +: 2];
      end
      if (commit && hit_chid) begin
        chid_r <= chid_new[IW-1:0];
      end
    end
  end

  // ****************************************
  // channel control b
  // ****************************************
  dcc_pkg::dcc_cfg_t [CH-1:0] cfg_r;
  logic [CH-1:0] susp_r;

  // R1 selected channel view
  wire dcc_pkg::dcc_cfg_t sel_cfg = cfg_r[chid_r];
  wire [31:0] cb_rd = {6'h0, dcc_pkg::CMD_IDLE, sel_cfg.trigger_consume_action, 6'h0,
    2'h0, sel_cfg.trig_src, 1'b0, sel_cfg.prio_lvl, sel_cfg.ev_out_en,
    sel_cfg.ev_in_en, sel_cfg.ev_action};
  wire [31:0] cb_new = dcc_pkg::dcc_be_merge(cb_rd, wd, be);
  wire [1:0] cmd_w = cb_new[dcc_pkg::CMD_LO +: 2];
  wire [1:0] trig_w = cb_new[dcc_pkg::TRIG_LO +: 2];
  wire cb_wr = commit & hit_cb;
  // R3 only the command lane gets through while enabled
  wire cfg_wr = cb_wr & !en_r;
  wire cmd_wr = cb_wr & be[3];
  // R4 R7 reserved trigger action keeps the old one
  wire trig_ok = trig_w != dcc_pkg::TRIG_RSVD;

  // the command field self-clears, so it always reads as the idle code
  generate
    for (genvar c = 0; c < CH; c++) begin : g_ch
      wire sel = chid_r == IW'(c);
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          cfg_r[c] <= dcc_pkg::CFG_RST;
          susp_r[c] <= 1'b0;
        end else begin
          // R1 R3 locked fields, selected channel only
          if (cfg_wr && sel) begin
            if (trig_ok) begin
              cfg_r[c].trigger_consume_action <= trig_w;
            end
            cfg_r[c].trig_src <= cb_new[dcc_pkg::SRC_LO +: 6];
            cfg_r[c].prio_lvl <= cb_new[dcc_pkg::LVL_LO +: 2];
            cfg_r[c].ev_out_en <= cb_new[dcc_pkg::EVOE_BIT];
            cfg_r[c].ev_in_en <= cb_new[dcc_pkg::EVIE_BIT];
            cfg_r[c].ev_action <= cb_new[dcc_pkg::EVACT_LO +: 3];
          end
          // R2 R7 suspend and resume, reserved code ignored
          if (cmd_wr && sel) begin
            if (cmd_w == dcc_pkg::CMD_SUSPEND) begin
              susp_r[c] <= 1'b1;
            end else if (cmd_w == dcc_pkg::CMD_RESUME) begin
              susp_r[c] <= 1'b0;
            end
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // checksum input
  // ****************************************
  logic [31:0] crc_in_r;
  logic [31:0] pend_r;
  logic [31:0] sum_r;
  logic [2:0] cnt_r;
  logic valid_r;
  wire [31:0] crc_new = dcc_pkg::dcc_be_merge(crc_in_r, wd, be);
  wire crc_wr = commit & hit_crc;

  // R5 R6 latency counter loads beat plus one; a new write restarts it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      crc_in_r <= dcc_pkg::CRC_IN_RST;
      pend_r <= dcc_pkg::CRC_SEED;
      sum_r <= dcc_pkg::CRC_SEED;
      cnt_r <= 3'h0;
      valid_r <= 1'b0;
    end else begin
      valid_r <= 1'b0;
      if (crc_wr) begin
        crc_in_r <= crc_new;
        pend_r <= dcc_pkg::dcc_crc_step(pend_r, crc_new);
        cnt_r <= {1'b0, beat_r} + 3'h1;
      end else if (cnt_r == 3'h1) begin
        cnt_r <= 3'h0;
        sum_r <= pend_r;
        valid_r <= 1'b1;
      end else if (cnt_r != 3'h0) begin
        cnt_r <= cnt_r - 3'h1;
      end
    end
  end

  // ****************************************
  // read mux and outputs
  // ****************************************
  wire [31:0] stat_rd = {31'h0, cnt_r != 3'h0};
  assign rd_mux = hit_ctrl ? ctrl_rd :
                  hit_crc ? crc_in_r :
                  hit_sum ? sum_r :
                  hit_stat ? stat_rd :
                  hit_chid ? {{(32-IW){1'b0}}, chid_r} :
                  hit_cb ? cb_rd : dcc_pkg::UNMAPPED_RD;

  assign avl_readdata = rdata_r;
  assign avl_waitrequest = wait_r;
  assign ctrl_enable = en_r;
  assign ch_suspended = susp_r;
  assign ch_cfg = cfg_r;
  assign crc_sum = sum_r;
  assign crc_valid = valid_r;

  // ****************************************
  // checks
  // ****************************************
  logic [3:0] since_r;
  logic [1:0] beat_lat_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      since_r <= 4'h0;
      beat_lat_r <= 2'h0;
    end else if (crc_wr) begin
      since_r <= 4'h1;
      beat_lat_r <= beat_r;
    end else if (since_r != 4'hF) begin
      since_r <= since_r + 4'h1;
    end
  end

  a_chid_route: assert property (@(posedge clk) disable iff (!rstn) // R1
    cfg_wr && be[1] |=> cfg_r[$past(chid_r)].trig_src == $past(wd[13:8]))
    else $error("config write missed the selected channel");
  a_cmd_suspend: assert property (@(posedge clk) disable iff (!rstn) // R2
    cmd_wr && wd[25:24] == 2'h1 |=> susp_r[$past(chid_r)])
    else $error("suspend command not applied");
  a_cmd_resume: assert property (@(posedge clk) disable iff (!rstn) // R2
    cmd_wr && wd[25:24] == 2'h2 |=> !susp_r[$past(chid_r)])
    else $error("resume command not applied");
  a_lock_fields: assert property (@(posedge clk) disable iff (!rstn) // R3
    cb_wr && en_r |=> $stable(cfg_r))
    else $error("locked field changed while enabled");
  a_trig_block: assert property (@(posedge clk) disable iff (!rstn) // R4
    cfg_wr && be[2] && wd[23:22] == 2'h0 |=>
    cfg_r[$past(chid_r)].trigger_consume_action == 2'h0)
    else $error("block trigger action not stored");
  a_crc_store: assert property (@(posedge clk) disable iff (!rstn) // R5
    crc_wr && be == 4'hF |=> crc_in_r == $past(wd))
    else $error("checksum input word not stored");
  a_crc_latency: assert property (@(posedge clk) disable iff (!rstn) // R6
    valid_r |-> since_r == {2'h0, beat_lat_r} + 4'h2)
    else $error("checksum valid at wrong cycle");
  a_rsvd_cmd: assert property (@(posedge clk) disable iff (!rstn) // R7
    cmd_wr && wd[25:24] == 2'h3 |=> $stable(susp_r))
    else $error("reserved command changed channel state");
  a_rsvd_trig: assert property (@(posedge clk) disable iff (!rstn) // R7
    cfg_wr && be[2] && wd[23:22] == 2'h1 |=>
    cfg_r[$past(chid_r)].trigger_consume_action == $past(sel_cfg.trigger_consume_action))
    else $error("reserved trigger action was stored");
endmodule
`default_nettype wire

// *** hdl/dcc_pkg.sv ***
// constants, types and helpers for the dma channel control and checksum input block
// What this block does
// R1: every channel control b access goes to the channel named by the selected channel index.
// R2: command 0 does nothing, 1 suspends, 2 resumes, 3 is reserved.
// R3: the command field is writable while enabled; other channel control b fields lock then.
// R4: trigger action 0 means one trigger per block transfer; code 1 is reserved.
// R5: a 32-bit read/write checksum input word resets to zero and feeds the checksum.
// R6: the new checksum is valid beat-size plus one cycles after the input word is written.
// R7: a reserved command or trigger action code leaves the channel state unchanged.
package dcc_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CRC_IN = 8'h04;
  localparam logic [7:0] OFF_CRC_SUM = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_CHAN_SEL = 8'h3C;
  localparam logic [7:0] OFF_CHAN_CTRL_B = 8'h44;
  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_EN_BIT = 1;
  localparam int CTRL_BEAT_LO = 2;
  localparam int CMD_LO = 24;
  localparam int TRIG_LO = 22;
  localparam int SRC_LO = 8;
  localparam int LVL_LO = 5;
  localparam int EVOE_BIT = 4;
  localparam int EVIE_BIT = 3;
  localparam int EVACT_LO = 0;
  localparam int STAT_BUSY_BIT = 0;
  // ****************************************
  // reset values and codes
  // ****************************************
  localparam logic [31:0] CRC_IN_RST = 32'h0000_0000;
  localparam logic [31:0] CRC_SEED = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_POLY = 32'h04C1_1DB7;
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
  localparam logic [1:0] BEAT_RST = 2'h0;
  localparam logic [1:0] CMD_IDLE = 2'h0;
  localparam logic [1:0] CMD_SUSPEND = 2'h1;
  localparam logic [1:0] CMD_RESUME = 2'h2;
  localparam logic [1:0] TRIG_BLOCK = 2'h0;
  localparam logic [1:0] TRIG_RSVD = 2'h1;

  typedef struct packed {
    logic [1:0] trigger_consume_action;
    logic [5:0] trig_src;
    logic [1:0] prio_lvl;
    logic ev_out_en;
    logic ev_in_en;
    logic [2:0] ev_action;
  } dcc_cfg_t;

  localparam dcc_cfg_t CFG_RST = '0;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } dcc_avl_req_t;

  typedef enum logic {BS_IDLE, BS_ACK} dcc_bus_st_t;

  function automatic logic [31:0] dcc_be_merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] dcc_crc_step(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      r = (r[31] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction
endpackage

// *** tb/tb.sv ***
// self-checking testbench for the dma channel control and checksum input block
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk;
  logic rstn;
  dcc_pkg::dcc_avl_req_t avl_req;
  logic [31:0] avl_readdata;
  logic avl_waitrequest;
  logic ctrl_enable;
  logic [3:0] ch_suspended;
  dcc_pkg::dcc_cfg_t [3:0] ch_cfg;
  logic [31:0] crc_sum;
  logic crc_valid;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  int commit_cyc = 0;
  logic [31:0] rd_q[$];
  logic [31:0] crc_q[$];
  int lat_q[$];
  logic [31:0] crc_m = 32'hFFFF_FFFF;
  logic [31:0] w;
  dcc_pkg::dcc_cfg_t [3:0] exp_cfg = '0;
  logic [3:0] exp_s = 4'h0;

  dcc_top #(.CH(4)) dut_u (.clk(clk), .rstn(rstn), .avl_req(avl_req),
    .avl_readdata(avl_readdata), .avl_waitrequest(avl_waitrequest),
    .ctrl_enable(ctrl_enable), .ch_suspended(ch_suspended), .ch_cfg(ch_cfg),
    .crc_sum(crc_sum), .crc_valid(crc_valid));

  always #5 clk = ~clk;

  // ****************************************
  // checking helpers
  // ****************************************
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    if (crc_q.size() != 0 || rd_q.size() != 0) err_count++;
    if (err_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // own reference, kept apart from the design's helper on purpose
  function automatic logic [31:0] crc_f(input logic [31:0] c, input logic [31:0] d);
    for (int i = 31; i >= 0; i--) c = (c[31] ^ d[i]) ? ((c << 1) ^ 32'h04C1_1DB7) : (c << 1);
    return c;
  endfunction

  function automatic dcc_pkg::dcc_cfg_t cmap(input logic [31:0] v);
    return {v[23:22], v[13:8], v[6:0]};
  endfunction

  // request held until waitrequest is sampled low or 50 cycles pass, released on that edge
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] be, input logic [31:0] ex);
    int n;
    n = 0;
    @(posedge clk);
    if (!wr) rd_q.push_back(ex);
    avl_req <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: be};
    do begin
      @(posedge clk);
      n++;
    end while (avl_waitrequest !== 1'b0 && n < 50);
    if (n == 50) err_count++;
    avl_req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    acc(1'b1, a, d, be, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    acc(1'b0, a, 32'h0, 4'hF, ex);
  endtask

  task automatic post;
    #1;
    chk(ch_cfg, exp_cfg);
    chk(ch_suspended, exp_s);
  endtask

  task automatic crcw(input logic [31:0] d, input int beat);
    int n;
    n = 0;
    lat_q.push_back(beat + 1);
    crc_m = crc_f(crc_m, d);
    crc_q.push_back(crc_m);
    wr(dcc_pkg::OFF_CRC_IN, d, 4'hF);
    while (crc_q.size() != 0 && n < 30) begin
      @(posedge clk);
      n++;
    end
    if (n == 30) err_count++;
    rd(dcc_pkg::OFF_CRC_IN, d);
    rd(dcc_pkg::OFF_CRC_SUM, crc_m);
  endtask

  // ****************************************
  // output watcher
  // ****************************************
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (avl_req.write && avl_waitrequest === 1'b0 && avl_req.address == dcc_pkg::OFF_CRC_IN)
      commit_cyc = cyc;
    if (avl_req.read && avl_waitrequest === 1'b0) chk(avl_readdata, rd_q.pop_front());
    if (crc_valid === 1'b1) begin
      chk(cyc - commit_cyc - 1, lat_q.pop_front());
      chk(crc_sum, crc_q.pop_front());
    end
  end

  initial begin
    #200000;
    err_count++;
    stop_test();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    clk = 0;
    rstn = 0;
    avl_req = '0;
    void'($urandom(32'hEEF7));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    post();
    rd(dcc_pkg::OFF_CRC_IN, 32'h0000_0000);
    rd(dcc_pkg::OFF_CHAN_CTRL_B, 32'h0000_0000);
    wr(8'h20, 32'hFFFF_FFFF, 4'hF);
    rd(8'h20, 32'h0000_0000);
    for (int b = 0; b < 4; b++) begin
      wr(dcc_pkg::OFF_CTRL, {28'h0, b[1:0], 2'h0}, 4'hF);
      crcw($urandom, b);
    end
    rd(dcc_pkg::OFF_STATUS, 32'h0000_0000);
    for (int c = 0; c < 4; c++) begin
      wr(dcc_pkg::OFF_CHAN_SEL, c, 4'hF);
      w = $urandom & 32'h00C0_3F7F;
      w[23:22] = (c == 0) ? 2'h0 : {1'b1, c[0]};
      exp_cfg[c] = cmap(w);
      exp_s[c] = 1'b1;
      wr(dcc_pkg::OFF_CHAN_CTRL_B, w | 32'h0100_0000, 4'hF);
      post();
      rd(dcc_pkg::OFF_CHAN_CTRL_B, w);
    end
    wr(dcc_pkg::OFF_CHAN_SEL, 32'h1, 4'hF);
    wr(dcc_pkg::OFF_CHAN_CTRL_B, 32'h02C0_3F7F, 4'h8);
    exp_s[1] = 1'b0;
    post();
    wr(dcc_pkg::OFF_CHAN_SEL, 32'h2, 4'hF);
    wr(dcc_pkg::OFF_CHAN_CTRL_B, 32'h0300_0000, 4'h8);
    post();
    wr(dcc_pkg::OFF_CHAN_SEL, 32'h3, 4'hF);
    wr(dcc_pkg::OFF_CHAN_CTRL_B, 32'h0040_0000, 4'h4);
    post();
    rd(dcc_pkg::OFF_CHAN_CTRL_B, w);
    // command accepted while enabled, config locked
    wr(dcc_pkg::OFF_CTRL, 32'h0000_0002, 4'hF);
    #1;
    chk(ctrl_enable, 1'b1);
    rd(dcc_pkg::OFF_CTRL, 32'h0000_0002);
    wr(dcc_pkg::OFF_CHAN_SEL, 32'h0, 4'hF);
    wr(dcc_pkg::OFF_CHAN_CTRL_B, 32'h0200_0000 | ($urandom & 32'h0080_3F7F), 4'hF);
    exp_s[0] = 1'b0;
    post();
    wr(dcc_pkg::OFF_CHAN_CTRL_B, 32'h0100_1234, 4'hF);
    exp_s[0] = 1'b1;
    post();
    stop_test();
  end
endmodule
`default_nettype wire
